// *** core/fidsr_core.sv ***
// Purpose: Serial flash identification and status readout with status protection checks
// Assumes: Serial clock well below clk_sys/6; host samples output on rising serial clock
// Notes: Non-volatile status bits take their defaults on rst_n

// Overview of operation
// - ID read: opcode, two dummies, address
// - ID bytes leave on falling edges, MSB first
// - Address 00h maker first, 01h device first
// - IDs alternate until chip select rises
// - Quad ID streams maker, type, density
// - Status read accepted even while busy
// - Status contents driven after status opcode
// - Config read any time, drives config
// - Opcode 8 or 2 clocks; upper lines ignored in single mode
// - Bit 0 busy while operation runs
// - Write commands need permit latch set
// - Writes to protected area are ignored
// - Bits 5..2 protect level, default zero
// - Full erase only with zero protect level
// - Quad enable disables lock and reset pin
// - Lock bit plus low protect pin locks
// - Lock and quad enable default to zero
module fidsr_core import fidsr_pkg::*; #(
  // Identification values; arbitrary neutral codes
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] DEVICE_ID = 8'h3c,
  parameter logic [7:0] MEMORY_TYPE = 8'h4b,
  parameter logic [7:0] MEMORY_DENSITY = 8'h2d
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Mode from the device
  input wire logic four_line_mode,
  input wire logic [7:0] config_value,
  // Operation state from the device
  input wire logic op_busy,
  input wire logic permit_set,
  input wire logic permit_clear,
  // Write-type command check
  input wire logic cmd_req,
  input wire logic [1:0] cmd_kind,
  input wire logic cmd_target_protected,
  input wire logic [7:0] cmd_status_data,
  output logic cmd_accept,
  output logic cmd_reject,
  // Status view
  output logic [7:0] device_status,
  output logic hardware_lock_mode,
  output logic reset_pin_enable
);

  // Synchronised pins
  logic sclk_q; // Serial clock after two stages
  logic cs_n_q; // Chip select after two stages
  logic [3:0] io_q; // Data lines after two stages
  logic sclk_prev; // Previous serial clock level
  logic sclk_rise; // Rising serial clock edge
  logic sclk_fall; // Falling serial clock edge
  logic selected; // Chip select is low

  // Frame state
  fidsr_state_type state;
  fidsr_src_type src;
  logic [7:0] rx_shift; // Incoming bits
  logic [7:0] next_rx_shift;
  logic [2:0] rx_cnt; // Bit position within byte
  logic [1:0] addr_cnt; // Byte within dummy/address phase
  logic swap_order; // Device ID goes first
  logic rx_done; // Current edge completes a byte
  logic [2:0] step; // Bits per serial clock
  logic [2:0] last_bit; // Position of last bit

  // Transmit state
  logic [7:0] tx_shift; // Remaining bits of byte being sent
  logic [2:0] tx_cnt; // Bit position within byte
  logic [1:0] tx_idx; // Byte number in stream
  logic [7:0] tx_byte; // Byte chosen for the next load

  // Protection state
  logic [3:0] protect_level;
  logic lock_active;
  logic busy_bit; // Busy flag register
  logic permit_bit; // Write permit latch
  logic [LOCK_BIT-PROT_LO:0] nv_bits; // Lock, quad enable and protect level
  fidsr_kind_type kind;

  // Pins come from another domain, so they are synchronised together
  fidsr_sync #(
    .WIDTH(6),
    .INIT(6'h02)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({io_in, cs_n, sclk}),
    .q({io_q, cs_n_q, sclk_q})
  );

  // Edge history of the serial clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_q;
    end
  end

  assign sclk_rise = sclk_q & ~sclk_prev;
  assign sclk_fall = ~sclk_q & sclk_prev;
  assign selected = ~cs_n_q;

  // Width per clock depends on command mode
  assign step = four_line_mode ? STEP_QUAD : STEP_SINGLE;
  assign last_bit = four_line_mode ? LAST_QUAD : LAST_SINGLE;
  assign rx_done = (rx_cnt == last_bit);

  // Single-line mode reads only the data-in line
  always_comb begin
    if (four_line_mode) begin
      next_rx_shift = {rx_shift[3:0], io_q};
    end else begin
      next_rx_shift = {rx_shift[6:0], io_q[0]};
    end
  end

  // Receive and decode; a high chip select ends any frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !selected) begin
      state <= ST_OPCODE;
      src <= SRC_STATUS;
      rx_shift <= 8'h00;
      rx_cnt <= 3'h0;
      addr_cnt <= 2'h0;
      swap_order <= 1'b0;
    end else if (sclk_rise) begin
      unique case (state)
        // Opcode phase: 8 or 2 clocks
        ST_OPCODE: begin
          rx_shift <= next_rx_shift;
          rx_cnt <= rx_done ? 3'h0 : rx_cnt + step;
          if (rx_done) begin
            if (next_rx_shift == OP_MAKER_DEVICE_ID_READ && !four_line_mode) begin
              state <= ST_ADDR;
              src <= SRC_MAKER_DEV;
            end else if (next_rx_shift == OP_QUAD_ID_READ && four_line_mode) begin
              state <= ST_SEND;
              src <= SRC_QUAD_ID;
            end else if (next_rx_shift == OP_STATUS_REG_READ) begin
              // No busy check here: reads stay open during operations
              state <= ST_SEND;
              src <= SRC_STATUS;
            end else if (next_rx_shift == OP_CONFIG_REG_READ) begin
              state <= ST_SEND;
              src <= SRC_CONFIG;
            end else begin
              // Other commands belong to other blocks
              state <= ST_IGNORE;
            end
          end
        end
        // Two dummy bytes then the address byte
        ST_ADDR: begin
          rx_shift <= next_rx_shift;
          rx_cnt <= rx_done ? 3'h0 : rx_cnt + step;
          if (rx_done) begin
            if (addr_cnt == ADDR_LAST_BYTE) begin
              swap_order <= next_rx_shift[0];
              state <= ST_SEND;
            end else begin
              addr_cnt <= addr_cnt + 2'h1;
            end
          end
        end
        // Output and ignored frames wait for chip select
        ST_SEND: begin
          rx_cnt <= 3'h0;
        end
        ST_IGNORE: begin
          rx_cnt <= 3'h0;
        end
      endcase
    end
  end

  // Byte choice for the next output byte
  always_comb begin
    unique case (src)
      SRC_MAKER_DEV: begin
        // Address bit 0 picks which ID leads; the pair alternates
        tx_byte = (tx_idx[0] ^ swap_order) ? DEVICE_ID : MAKER_ID;
      end
      SRC_QUAD_ID: begin
        if (tx_idx == 2'h0) begin
          tx_byte = MAKER_ID;
        end else if (tx_idx == 2'h1) begin
          tx_byte = MEMORY_TYPE;
        end else begin
          tx_byte = MEMORY_DENSITY;
        end
      end
      SRC_STATUS: begin
        // Sampled afresh at each byte so busy changes show
        tx_byte = device_status;
      end
      SRC_CONFIG: begin
        tx_byte = config_value;
      end
    endcase
  end

  // Transmit on falling serial clock edges, MSB first
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !selected) begin
      io_out <= 4'h0;
      io_oe <= OE_NONE;
      tx_shift <= 8'h00;
      tx_cnt <= 3'h0;
      tx_idx <= 2'h0;
    end else if (sclk_fall && state == ST_SEND) begin
      tx_cnt <= rx_done_tx(tx_cnt, last_bit) ? 3'h0 : tx_cnt + step;
      if (four_line_mode) begin
        io_oe <= OE_QUAD;
        if (tx_cnt == 3'h0) begin
          io_out <= tx_byte[7:4];
          tx_shift <= {tx_byte[3:0], 4'h0};
        end else begin
          io_out <= tx_shift[7:4];
          tx_shift <= {tx_shift[3:0], 4'h0};
        end
      end else begin
        // Single-line output uses the data-out line only
        io_oe <= OE_SINGLE;
        if (tx_cnt == 3'h0) begin
          io_out <= {2'b00, tx_byte[7], 1'b0};
          tx_shift <= {tx_byte[6:0], 1'b0};
        end else begin
          io_out <= {2'b00, tx_shift[7], 1'b0};
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end
      // Advance byte number at byte end, quad ID wraps after density
      if (rx_done_tx(tx_cnt, last_bit)) begin
        if (src == SRC_QUAD_ID && tx_idx == QUAD_ID_LAST) begin
          tx_idx <= 2'h0;
        end else begin
          tx_idx <= tx_idx + 2'h1;
        end
      end
    end
  end

  // Byte end test shared by transmit paths
  function automatic logic rx_done_tx(input logic [2:0] cnt, input logic [2:0] last);
    rx_done_tx = (cnt == last);
  endfunction

  assign protect_level = device_status[PROT_HI:PROT_LO];
  assign kind = fidsr_kind_type'(cmd_kind);
  // Lock needs lock bit, low protect pin, and quad mode off
  assign lock_active = device_status[LOCK_BIT] & ~io_q[2] & ~device_status[QE_BIT];

  // Status byte is the three status registers side by side
  // Separate registers keep each bit group to a single process
  assign device_status = {nv_bits, permit_bit, busy_bit};

  // Busy flag follows the running operation
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_bit <= 1'b0;
    end else begin
      busy_bit <= op_busy;
    end
  end

  // Permit latch: a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      permit_bit <= 1'b0;
    end else if (permit_set) begin
      permit_bit <= 1'b1;
    end else if (permit_clear) begin
      permit_bit <= 1'b0;
    end
  end

  // Non-volatile bits change only through an accepted status write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nv_bits <= STATUS_RESET[LOCK_BIT:PROT_LO];
    end else if (cmd_req && kind == KIND_STATUS_WRITE
                 && permit_bit && !lock_active) begin
      nv_bits <= cmd_status_data[LOCK_BIT:PROT_LO];
    end
  end

  // Check each write-type request against latch and protection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
    end else if (cmd_req) begin
      if (!device_status[PERMIT_BIT]) begin
        cmd_accept <= 1'b0;
        cmd_reject <= 1'b1;
      end else begin
        unique case (kind)
          KIND_PAGE_WRITE, KIND_AREA_WIPE: begin
            cmd_accept <= !cmd_target_protected;
            cmd_reject <= cmd_target_protected;
          end
          KIND_FULL_WIPE: begin
            cmd_accept <= (protect_level == PROT_NONE);
            cmd_reject <= (protect_level != PROT_NONE);
          end
          KIND_STATUS_WRITE: begin
            cmd_accept <= !lock_active;
            cmd_reject <= lock_active;
          end
        endcase
      end
    end else begin
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
    end
  end

  // Protection mode outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hardware_lock_mode <= 1'b0;
      reset_pin_enable <= 1'b1;
    end else begin
      hardware_lock_mode <= lock_active;
      reset_pin_enable <= ~device_status[QE_BIT];
    end
  end

endmodule

// *** core/fidsr_pkg.sv ***
// Purpose: Shared constants and types for the flash ID and status readout block
// Assumes: Serial clock mode 0 or 3, commands sampled on rising serial clock edges
// Notes: Status bit positions and reset values live here only
package fidsr_pkg;

  // Command opcodes
  localparam logic [7:0] OP_MAKER_DEVICE_ID_READ = 8'h90;
  localparam logic [7:0] OP_QUAD_ID_READ = 8'haf;
  localparam logic [7:0] OP_STATUS_REG_READ = 8'h05;
  localparam logic [7:0] OP_CONFIG_REG_READ = 8'h15;

  // Bits per serial clock and last bit position of a byte
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;
  localparam logic [2:0] LAST_SINGLE = 3'h7;
  localparam logic [2:0] LAST_QUAD = 3'h4;

  // Two dummy bytes then one address byte
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  // Quad ID sequence: maker, memory type, density
  localparam logic [1:0] QUAD_ID_LAST = 2'h2;

  // Output enables while sending
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam logic [3:0] OE_NONE = 4'h0;

  // Status register layout
  localparam int BUSY_BIT = 0;
  localparam int PERMIT_BIT = 1;
  localparam int PROT_LO = 2;
  localparam int PROT_HI = 5;
  localparam int QE_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] PROT_NONE = 4'h0;

  // Write-type command kinds checked against the status register
  typedef enum logic [1:0] {
    KIND_PAGE_WRITE,
    KIND_AREA_WIPE,
    KIND_FULL_WIPE,
    KIND_STATUS_WRITE
  } fidsr_kind_type;

  // Serial frame states
  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_SEND,
    ST_IGNORE
  } fidsr_state_type;

  // Source of the bytes being sent
  typedef enum logic [1:0] {
    SRC_MAKER_DEV,
    SRC_QUAD_ID,
    SRC_STATUS,
    SRC_CONFIG
  } fidsr_src_type;

endpackage

// *** core/fidsr_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes: Only the second stage is visible outside
module fidsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1; // Metastable stage, read by q only

  // Both stages reset to a constant
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1 <= INIT;
      q <= INIT;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

// *** sim/fidsr_core_props.sv ***
// Purpose: Port-level checks for the readout core
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound into every core instance at the foot of this file
module fidsr_core_props import fidsr_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  // Device state
  input wire logic op_busy,
  input wire logic permit_set,
  input wire logic [7:0] device_status,
  input wire logic hardware_lock_mode,
  input wire logic reset_pin_enable,
  // Command check
  input wire logic cmd_req,
  input wire logic [1:0] cmd_kind,
  input wire logic cmd_target_protected,
  input wire logic [7:0] cmd_status_data,
  input wire logic cmd_accept,
  input wire logic cmd_reject
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Three cycles leave room for a registered copy of the busy input
  a_busy_follows: assert property (op_busy [*3] |-> device_status[BUSY_BIT])
    else $error("busy bit low while busy");
  a_idle_clear: assert property (!op_busy [*3] |-> !device_status[BUSY_BIT])
    else $error("busy bit high while idle");
  a_permit_sets: assert property (permit_set |-> ##[1:2] device_status[PERMIT_BIT])
    else $error("permit bit not set");
  a_no_permit: assert property (cmd_req && !device_status[PERMIT_BIT] |=> cmd_reject && !cmd_accept)
    else $error("command taken without permit");
  a_prot_target: assert property (cmd_req && cmd_target_protected
    && cmd_kind != KIND_STATUS_WRITE |=> cmd_reject) else $error("protected target taken");
  a_full_wipe: assert property (cmd_req && cmd_kind == KIND_FULL_WIPE
    && device_status[PROT_HI:PROT_LO] != PROT_NONE |=> cmd_reject) else $error("full wipe while protected");
  a_lock_refuse: assert property (cmd_req && cmd_kind == KIND_STATUS_WRITE && hardware_lock_mode
    |=> cmd_reject) else $error("status write under lock");
  a_write_lands: assert property (cmd_accept && $past(cmd_kind) == KIND_STATUS_WRITE
    |-> device_status[LOCK_BIT:PROT_LO] == $past(cmd_status_data[7:2])) else $error("status write lost");
  // A changing enable may show its effect one cycle late
  a_pin_follow: assert property ($stable(device_status[QE_BIT])
    |-> reset_pin_enable == !device_status[QE_BIT]) else $error("reset pin enable wrong");
  a_idle_lines: assert property (cs_n [*5] |-> io_oe == OE_NONE)
    else $error("driving while deselected");
endmodule

bind fidsr_core fidsr_core_props i_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .io_oe(io_oe), .op_busy(op_busy),
  .permit_set(permit_set), .device_status(device_status), .hardware_lock_mode(hardware_lock_mode),
  .reset_pin_enable(reset_pin_enable), .cmd_req(cmd_req), .cmd_kind(cmd_kind),
  .cmd_target_protected(cmd_target_protected), .cmd_status_data(cmd_status_data),
  .cmd_accept(cmd_accept), .cmd_reject(cmd_reject)
);

// *** sim/fidsr_host_model.sv ***
// Purpose: Host serial controller facing the readout core
// Assumes: Clock idles low, 320 ns period, stands still between frames
// Notes: Released lines toggle, so stale data never reads as valid
module fidsr_host_model (
  // Serial pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  // Device drive and enables
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // Protect pin level and command mode
  input wire logic wp_n,
  input wire logic quad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hd = 4'h8; // Host drive per line
  logic [7:0] rx [0:7]; // Bytes read back
  logic drove = 1'b0; // Device drove during the frame
  // Idle pins
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Wire level; upper lines carry hold and protect in single mode
  assign io_in = (io_oe & io_out) | (~io_oe & (quad ? hd : {1'b1, wp_n, hd[1:0]}));
  // One byte out, MSB first, taken on rising edges
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      if (quad)
        hd = b[7-4*i -: 4];
      else
        hd[0] = b[7-i];
      #160 sclk = 1'b1;
      #160 sclk = 1'b0;
    end
  endtask
  // One byte in, sampled late in the high phase where it is settled
  task automatic get(output logic [7:0] b);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      hd = ~hd;
      #160 sclk = 1'b1;
      #150 b = quad ? {b[3:0], io_in} : {b[6:0], io_in[1]};
      drove = drove | (|io_oe);
      #10 sclk = 1'b0;
    end
  endtask
  // Whole frame: opcode, optional dummies and address, then reads
  task automatic frame(input logic [7:0] op, input logic adr_on, input logic [7:0] adr, input int n);
    #7 drove = 1'b0;
    cs_n = 1'b0;
    put(op);
    if (adr_on) begin
      put(8'h00);
      put(8'h00);
      put(adr);
    end
    for (int k = 0; k < n; k++) get(rx[k]);
    #160 cs_n = 1'b1;
    hd = ~hd;
    #480;
  endtask
endmodule

// *** sim/fidsr_core_tb_top.sv ***
// Purpose: Self-checking bench for the readout core
// Assumes: Host model owns the serial pins
// Notes: Bench inputs change on falling clk_sys edges only
module fidsr_core_tb_top import fidsr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // Identification values, arbitrary
  localparam logic [7:0] ID_M = 8'h5a, ID_D = 8'h3c, ID_T = 8'h4b, ID_S = 8'h2d;
  logic clk_sys = 1'b0, rst_n = 1'b0, wp_n = 1'b1;
  logic four_line_mode = 1'b0, op_busy = 1'b0, permit_set = 1'b0, permit_clear = 1'b0;
  logic cmd_req = 1'b0, cmd_target_protected = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [7:0] config_value = 8'ha5, cmd_status_data = 8'h00;
  logic sclk, cs_n, cmd_accept, cmd_reject, hardware_lock_mode, reset_pin_enable;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] device_status;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;

  fidsr_core #(.MAKER_ID(ID_M), .DEVICE_ID(ID_D), .MEMORY_TYPE(ID_T), .MEMORY_DENSITY(ID_S)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .four_line_mode(four_line_mode), .config_value(config_value), .op_busy(op_busy),
    .permit_set(permit_set), .permit_clear(permit_clear), .cmd_req(cmd_req), .cmd_kind(cmd_kind),
    .cmd_target_protected(cmd_target_protected), .cmd_status_data(cmd_status_data),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .device_status(device_status),
    .hardware_lock_mode(hardware_lock_mode), .reset_pin_enable(reset_pin_enable));
  fidsr_host_model i_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .wp_n(wp_n), .quad(four_line_mode));

  // System clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Set or clear the permit latch with a one-cycle pulse
  task automatic pulse_permit(input logic clr);
    @(negedge clk_sys);
    permit_set = !clr;
    permit_clear = clr;
    @(negedge clk_sys);
    permit_set = 1'b0;
    permit_clear = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // One write-type command, judged on the cycle after it is taken
  task automatic cmd(input logic [1:0] kind, input logic prot, input logic [7:0] data, input logic ok);
    @(negedge clk_sys);
    cmd_req = 1'b1;
    cmd_kind = kind;
    cmd_target_protected = prot;
    cmd_status_data = data;
    @(negedge clk_sys);
    cmd_req = 1'b0;
    check("accept", {7'h0, cmd_accept}, {7'h0, ok});
    check("reject", {7'h0, cmd_reject}, {7'h0, !ok});
    repeat (4) @(negedge clk_sys);
  endtask
  // Both address orders, four bytes each so alternation shows
  task automatic t_ids();
    for (int a = 0; a < 2; a++) begin
      i_host.frame(OP_MAKER_DEVICE_ID_READ, 1'b1, a[7:0], 4);
      for (int k = 0; k < 4; k++) check("id", i_host.rx[k], (k[0] ^ a[0]) ? ID_D : ID_M);
    end
  endtask
  // Busy drops mid-frame; only the second byte may show it
  task automatic t_status_live();
    @(negedge clk_sys);
    op_busy = 1'b1;
    pulse_permit(1'b0);
    fork
      i_host.frame(OP_STATUS_REG_READ, 1'b0, 8'h00, 2);
      begin
        repeat (75) @(negedge clk_sys);
        op_busy = 1'b0;
      end
    join
    check("sr busy", i_host.rx[0], 8'h03);
    check("sr live", i_host.rx[1], 8'h02);
    pulse_permit(1'b1);
    i_host.frame(OP_STATUS_REG_READ, 1'b0, 8'h00, 1);
    check("sr idle", i_host.rx[0], 8'h00);
  endtask
  // Config reads, a refused frame, then four-line reads
  task automatic t_config_quad();
    logic [7:0] qid [4] = '{ID_M, ID_T, ID_S, ID_M};
    i_host.frame(OP_CONFIG_REG_READ, 1'b0, 8'h00, 2);
    for (int k = 0; k < 2; k++) check("cfg", i_host.rx[k], 8'ha5);
    i_host.frame(OP_QUAD_ID_READ, 1'b0, 8'h00, 1);
    check("refused", {7'h0, i_host.drove}, 8'h00);
    @(negedge clk_sys);
    four_line_mode = 1'b1;
    i_host.frame(OP_CONFIG_REG_READ, 1'b0, 8'h00, 1);
    check("qcfg", i_host.rx[0], 8'ha5);
    i_host.frame(OP_STATUS_REG_READ, 1'b0, 8'h00, 1);
    check("qsr", i_host.rx[0], 8'h00);
    i_host.frame(OP_QUAD_ID_READ, 1'b0, 8'h00, 4);
    for (int k = 0; k < 4; k++) check("qid", i_host.rx[k], qid[k]);
    @(negedge clk_sys);
    four_line_mode = 1'b0;
  endtask
  // Permit, protection, full wipe, lock and quad enable
  task automatic t_cmds();
    cmd(KIND_PAGE_WRITE, 1'b0, 8'h00, 1'b0);
    pulse_permit(1'b0);
    cmd(KIND_PAGE_WRITE, 1'b1, 8'h00, 1'b0);
    cmd(KIND_AREA_WIPE, 1'b0, 8'h00, 1'b1);
    cmd(KIND_STATUS_WRITE, 1'b0, 8'h3c, 1'b1);
    check("level", device_status, 8'h3e);
    cmd(KIND_FULL_WIPE, 1'b0, 8'h00, 1'b0);
    cmd(KIND_STATUS_WRITE, 1'b0, 8'h00, 1'b1);
    cmd(KIND_FULL_WIPE, 1'b0, 8'h00, 1'b1);
    wp_n = 1'b0;
    cmd(KIND_STATUS_WRITE, 1'b0, 8'h80, 1'b1);
    check("lock", {7'h0, hardware_lock_mode}, 8'h01);
    cmd(KIND_STATUS_WRITE, 1'b0, 8'h00, 1'b0);
    wp_n = 1'b1;
    // Protect pin needs its two sync stages before the lock lifts
    repeat (3) @(negedge clk_sys);
    cmd(KIND_STATUS_WRITE, 1'b0, 8'hc0, 1'b1);
    wp_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("qe lock", {7'h0, hardware_lock_mode}, 8'h00);
    check("rst pin", {7'h0, reset_pin_enable}, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("status", device_status, STATUS_RESET);
    check("rst pin", {7'h0, reset_pin_enable}, 8'h01);
    t_ids();
    t_status_live();
    t_config_quad();
    t_cmds();
    report_and_stop();
  end
endmodule
